// ==== inc/cdo_pkg.sv ====
// cd audio output port: shared constants, register map and carrier types
// assumes a 20 MHz system clock; all other rates are derived from it
package cdo_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam longint CDO_CLK_HZ          = 64'd20_000_000;
    localparam longint CDO_XTAL_LO_HZ      = 64'd16_934_400;
    localparam longint CDO_XTAL_HI_HZ      = 64'd33_868_800;
    localparam int     CDO_NCO_BITS        = 16;
    // nco increments: tick rate = crystal rate (high crystal is halved first)
    localparam logic [15:0] CDO_INC_LO     = 16'((CDO_XTAL_LO_HZ * 64'd65536) / CDO_CLK_HZ);
    localparam logic [15:0] CDO_INC_HI     = 16'((CDO_XTAL_HI_HZ * 64'd65536) / (64'd2 * CDO_CLK_HZ));
    localparam int     CDO_LOCK_SAMPLE_HZ  = 460;
    localparam int     CDO_LOCK_SAMPLE_CYC = int'(CDO_CLK_HZ / 64'(CDO_LOCK_SAMPLE_HZ));
    localparam int     CDO_LOCK_LOW_RUN    = 8;
    localparam int     CDO_BURST_FRAMES    = 16;

    // ------------------------------------------------------------------
    // audio framing: 384 ticks per sample, 6 per 64-slot bit, 8 per 48-slot bit
    // ------------------------------------------------------------------
    localparam int     CDO_AUDIO_BITS      = 16;
    localparam int     CDO_TICKS_FRAME     = 384;
    localparam int     CDO_TICKS_BIT64     = 6;
    localparam int     CDO_TICKS_BIT48     = 8;
    localparam int     CDO_SLOT48          = 48;
    localparam int     CDO_SLOT64          = 64;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] CDO_CTRL_OFF   = 12'h000;
    localparam logic [11:0] CDO_PITCH_OFF  = 12'h004;
    localparam logic [11:0] CDO_STATUS_OFF = 12'h008;
    localparam int     CDO_CTRL_PAR        = 0;
    localparam int     CDO_CTRL_XTAL       = 1;
    localparam int     CDO_CTRL_DOUT       = 2;
    localparam int     CDO_CTRL_SPIN       = 3;
    localparam int     CDO_CTRL_SEQ        = 4;
    localparam int     CDO_CTRL_W          = 5;
    localparam logic [4:0]  CDO_CTRL_RESET = 5'h00;
    localparam logic [15:0] CDO_PITCH_RESET = CDO_INC_LO;
    localparam int     CDO_ST_LOCK         = 0;
    localparam int     CDO_ST_OVF          = 1;
    localparam int     CDO_ST_FOCUS        = 2;
    localparam int     CDO_ST_PAR          = 3;
    localparam int     CDO_ST_LEVEL        = 8;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cdo_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cdo_apb_rsp_type;

    typedef struct packed {
        logic       sync_guard_flag;
        logic       unguarded_frame_n;
        logic       pll_clock_n;
        logic       c2_pointer;
        logic [3:0] monitor_bit;
    } cdo_mon_type;

    typedef struct packed {
        logic        err;
        logic [15:0] left;
        logic [15:0] right;
    } cdo_sample_type;

endpackage : cdo_pkg

// ==== src/cdo_audio_out.sv ====
// cd audio output port: buffer, serial/parallel audio pins, clocks, lock
// assumes apb master and sample writer on CLK; status pins are asynchronous
`timescale 1ns/10ps
module cdo_audio_out #(
    parameter int DEPTH          = 16,
    parameter int LOCK_SAMPLE_CYC = cdo_pkg::CDO_LOCK_SAMPLE_CYC
) (
    input  wire logic                     CLK,
    input  wire logic                     RSTN,
    input  wire cdo_pkg::cdo_apb_req_type APB_REQ,
    output      cdo_pkg::cdo_apb_rsp_type APB_RSP,
    input  wire logic                     AUD_WR,
    input  wire cdo_pkg::cdo_sample_type  AUD_SAMPLE,
    input  wire logic                     FRAME_SYNC_GOOD,
    input  wire logic                     FOCUS_GOOD,
    input  wire cdo_pkg::cdo_mon_type     MON_IN,
    output      logic [15:0]              AUDIO_PINS,
    output      logic                     WORD_CLOCK_OUT,
    output      logic                     CHAN_CLOCK_OUT,
    output      logic                     APERTURE_RIGHT,
    output      logic                     APERTURE_LEFT,
    output      logic                     LOCK,
    output      logic                     TWO_THIRDS_CLOCK,
    output      logic                     CLK_4MHZ_OUT,
    output      logic                     CLK_HI_OUT,
    output      logic                     DIG_OUT,
    output      logic                     DIG_OUT_ENABLE,
    output      logic                     SENSE_REPORT,
    output      logic                     SEQ_GATE,
    output      logic                     SPINDLE_ON
);
    import cdo_pkg::*;

    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(LOCK_SAMPLE_CYC + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 2");
    end
    if (LOCK_SAMPLE_CYC < 2) begin : g_bad_lock
        $error("LOCK_SAMPLE_CYC must be at least 2");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        cdo_apb_rsp_type                  rsp;
        logic [CDO_CTRL_W-1:0]            ctrl;
        logic [15:0]                      pitch;
        logic                             ovf;
        logic                             fsg_s1;
        logic                             fsg_s2;
        logic                             foc_s1;
        logic                             foc_s2;
        cdo_mon_type                      mon_s1;
        cdo_mon_type                      mon_s2;
        logic [15:0]                      fixed_acc;
        logic [15:0]                      pitch_acc;
        logic [1:0]                       tt_phase;
        logic                             c4_div;
        logic [8:0]                       pos;
        logic [2:0]                       c6;
        logic [5:0]                       b64;
        logic [2:0]                       c8;
        logic [5:0]                       b48;
        logic                             par;
        cdo_sample_type                   cur;
        logic [4:0]                       burst;
        logic [DEPTH-1:0][32:0]           mem;
        logic [AW-1:0]                    wr_ptr;
        logic [AW-1:0]                    rd_ptr;
        logic [AW:0]                      level;
        logic [LW-1:0]                    lock_cnt;
        logic [3:0]                       low_run;
        logic                             lock;
        logic [15:0]                      pins;
        logic                             word_clk;
        logic                             chan_clk;
        logic                             apt_r;
        logic                             apt_l;
        logic                             two_thirds;
        logic                             clk4;
        logic                             clk_hi;
        logic                             dig_out;
        logic                             dig_en;
        logic                             sense;
        logic                             seq_gate;
        logic                             spindle;
    } cdo_state_type;

    cdo_state_type st;
    cdo_state_type next_st;

    // ------------------------------------------------------------------
    // register decode, shared by read and write paths
    // ------------------------------------------------------------------
    function automatic logic [1:0] reg_index(input logic [11:0] addr);
        logic [1:0] idx;
        idx = 2'h3;
        if (addr == CDO_CTRL_OFF)   idx = 2'h0;
        if (addr == CDO_PITCH_OFF)  idx = 2'h1;
        if (addr == CDO_STATUS_OFF) idx = 2'h2;
        return idx;
    endfunction : reg_index

    // combinational temporaries
    logic           fix_carry;
    logic           pit_carry;
    logic           frame_end;
    logic           in_left;
    logic [5:0]     k48;
    logic [5:0]     k64;
    logic [15:0]    chan_s;
    logic           bit48;
    logic           bit64;
    logic           wr_go;
    logic           rd_go;
    logic           acc;
    logic           commit;
    logic [31:0]    rdata;
    cdo_sample_type rd_word;
    logic [AW:0]    lvl_next;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st   = st;
        fix_carry = 1'b0;
        pit_carry = 1'b0;
        frame_end = 1'b0;
        in_left   = 1'b0;
        k48       = 6'h00;
        k64       = 6'h00;
        chan_s    = 16'h0000;
        bit48     = 1'b0;
        bit64     = 1'b0;
        rdata     = 32'h0000_0000;
        rd_word   = cdo_sample_type'(st.mem[st.rd_ptr]);
        lvl_next  = st.level;

        // status pins are asynchronous: two flops before any use
        next_st.fsg_s1 = FRAME_SYNC_GOOD;
        next_st.fsg_s2 = st.fsg_s1;
        next_st.foc_s1 = FOCUS_GOOD;
        next_st.foc_s2 = st.foc_s1;
        next_st.mon_s1 = MON_IN;
        next_st.mon_s2 = st.mon_s1;

        // apb: pready comes one cycle into the access phase, write lands with it
        acc    = APB_REQ.psel && APB_REQ.penable;
        commit = acc && st.rsp.pready;
        next_st.rsp.pready = acc && !st.rsp.pready;
        if (acc && !st.rsp.pready) begin
            unique case (reg_index(APB_REQ.paddr))
                2'h0: rdata = 32'(st.ctrl);
                2'h1: rdata = 32'(st.pitch);
                2'h2: begin
                    rdata[CDO_ST_LOCK]  = st.lock;
                    rdata[CDO_ST_OVF]   = st.ovf;
                    rdata[CDO_ST_FOCUS] = st.foc_s2;
                    rdata[CDO_ST_PAR]   = st.par;
                    rdata[CDO_ST_LEVEL +: AW + 1] = st.level;
                end
                2'h3: rdata = 32'h0000_0000;
            endcase
            next_st.rsp.prdata  = rdata;
            next_st.rsp.pslverr = (reg_index(APB_REQ.paddr) == 2'h3);
        end
        if (commit && APB_REQ.pwrite) begin
            unique case (reg_index(APB_REQ.paddr))
                2'h0: next_st.ctrl  = APB_REQ.pwdata[CDO_CTRL_W-1:0];
                2'h1: next_st.pitch = APB_REQ.pwdata[15:0];
                2'h2: if (APB_REQ.pwdata[CDO_ST_OVF]) next_st.ovf = 1'b0;
                2'h3: next_st.ctrl  = st.ctrl;
            endcase
        end

        // crystal tick: high crystal is halved so the tick rate is equal; pitch has no effect
        {fix_carry, next_st.fixed_acc} = {1'b0, st.fixed_acc}
            + {1'b0, (st.ctrl[CDO_CTRL_XTAL] ? CDO_INC_HI : CDO_INC_LO)};
        if (fix_carry) begin
            next_st.tt_phase = (st.tt_phase == 2'h2) ? 2'h0 : st.tt_phase + 2'h1;
            if (st.tt_phase != 2'h2) next_st.two_thirds = !st.two_thirds;
        end

        // pitched tick: nominal 384 Fs, steered by the pitch register
        {pit_carry, next_st.pitch_acc} = {1'b0, st.pitch_acc} + {1'b0, st.pitch};
        if (pit_carry) begin
            next_st.clk_hi = !st.clk_hi;
            next_st.c4_div = !st.c4_div;
            if (st.c4_div) next_st.clk4 = !st.clk4;
            next_st.pos = (st.pos == 9'(CDO_TICKS_FRAME - 1)) ? 9'h000 : st.pos + 9'h001;
            next_st.c6  = (st.c6 == 3'(CDO_TICKS_BIT64 - 1)) ? 3'h0 : st.c6 + 3'h1;
            next_st.c8  = (st.c8 == 3'(CDO_TICKS_BIT48 - 1)) ? 3'h0 : st.c8 + 3'h1;
            if (st.c6 == 3'(CDO_TICKS_BIT64 - 1)) begin
                next_st.b64 = (st.b64 == 6'(CDO_SLOT64 - 1)) ? 6'h00 : st.b64 + 6'h01;
            end
            if (st.c8 == 3'(CDO_TICKS_BIT48 - 1)) begin
                next_st.b48 = (st.b48 == 6'(CDO_SLOT48 - 1)) ? 6'h00 : st.b48 + 6'h01;
            end
            frame_end = (st.pos == 9'(CDO_TICKS_FRAME - 1));
        end

        // buffer write: only while frame sync is good
        wr_go = AUD_WR && st.fsg_s2 && (st.level != (AW + 1)'(DEPTH));
        if (wr_go) begin
            next_st.mem[st.wr_ptr] = AUD_SAMPLE;
            next_st.wr_ptr = st.wr_ptr + AW'(1);
        end
        // overflow flag: a new overflow beats a clear in the same cycle
        if (AUD_WR && st.fsg_s2 && !wr_go) next_st.ovf = 1'b1;

        // buffer read on the pitched-tick frame boundary
        rd_go = frame_end && (st.level != '0);
        if (rd_go) next_st.rd_ptr = st.rd_ptr + AW'(1);
        if (wr_go && !rd_go) lvl_next = st.level + (AW + 1)'(1);
        if (rd_go && !wr_go) lvl_next = st.level - (AW + 1)'(1);
        next_st.level = lvl_next;

        // new word and format change only at the frame boundary
        if (frame_end) begin
            next_st.par = st.ctrl[CDO_CTRL_PAR];
            if (rd_go && !rd_word.err) begin
                next_st.cur   = rd_word;
                next_st.burst = 5'h00;
            end else if (st.burst < 5'(CDO_BURST_FRAMES)) begin
                // hold the last good word over a burst of up to 16 frames
                next_st.burst   = st.burst + 5'h01;
                next_st.cur.err = 1'b1;
            end else begin
                next_st.cur = '0;
            end
        end

        // channel half and slot bit positions
        in_left = (st.pos < 9'(CDO_TICKS_FRAME / 2));
        chan_s  = in_left ? st.cur.left : st.cur.right;
        k48     = in_left ? st.b48 : st.b48 - 6'(CDO_SLOT48 / 2);
        k64     = in_left ? st.b64 : st.b64 - 6'(CDO_SLOT64 / 2);
        // 48 slot: 8 sign bits then data msb first
        bit48   = (k48 < 6'h08) ? chan_s[15] : chan_s[4'(6'd23 - k48)];
        // 64 slot: data lsb first then sign extension
        bit64   = (k64 < 6'(CDO_AUDIO_BITS)) ? chan_s[k64[3:0]] : chan_s[15];

        next_st.chan_clk = in_left;
        next_st.word_clk = (st.pos < 9'(CDO_TICKS_FRAME / 4))
                        || ((st.pos >= 9'(CDO_TICKS_FRAME / 2))
                        && (st.pos < 9'(3 * CDO_TICKS_FRAME / 4)));
        next_st.apt_l    = in_left;
        next_st.apt_r    = !in_left;

        // pin mux: parallel word or serial lines plus status
        if (st.par) begin
            next_st.pins = chan_s;
        end else begin
            next_st.pins[15] = bit48;
            next_st.pins[14] = (st.c8 >= 3'(CDO_TICKS_BIT48 / 2));
            next_st.pins[13] = bit64;
            next_st.pins[12] = (st.c6 >= 3'(CDO_TICKS_BIT64 / 2));
            next_st.pins[11] = in_left;
            next_st.pins[10] = st.mon_s2.sync_guard_flag;
            next_st.pins[9]  = st.mon_s2.unguarded_frame_n;
            next_st.pins[8]  = st.mon_s2.pll_clock_n;
            next_st.pins[7]  = st.fsg_s2;
            next_st.pins[6]  = in_left;
            next_st.pins[5]  = st.mon_s2.c2_pointer;
            next_st.pins[4]  = !st.ovf;
            next_st.pins[3:0] = st.mon_s2.monitor_bit;
        end

        // lock: sample frame sync good at 460 Hz
        if (st.lock_cnt == LW'(LOCK_SAMPLE_CYC - 1)) begin
            next_st.lock_cnt = '0;
            if (st.fsg_s2) begin
                next_st.lock    = 1'b1;
                next_st.low_run = 4'h0;
            end else if (st.low_run < 4'(CDO_LOCK_LOW_RUN)) begin
                next_st.low_run = st.low_run + 4'h1;
                if (st.low_run == 4'(CDO_LOCK_LOW_RUN - 1)) next_st.lock = 1'b0;
            end
        end else begin
            next_st.lock_cnt = st.lock_cnt + LW'(1);
        end

        // loose control and sense outputs
        next_st.dig_en   = st.ctrl[CDO_CTRL_DOUT];
        next_st.dig_out  = st.ctrl[CDO_CTRL_DOUT] && bit64;
        next_st.sense    = st.foc_s2;
        next_st.seq_gate = st.foc_s2 && st.ctrl[CDO_CTRL_SEQ];
        next_st.spindle  = st.ctrl[CDO_CTRL_SPIN];
    end

    // ------------------------------------------------------------------
    // state register; reset clears everything but the nominal pitch
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st       <= '0;
            st.ctrl  <= CDO_CTRL_RESET;
            st.pitch <= CDO_PITCH_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from the state flops
    // ------------------------------------------------------------------
    assign APB_RSP          = st.rsp;
    assign AUDIO_PINS       = st.pins;
    assign WORD_CLOCK_OUT   = st.word_clk;
    assign CHAN_CLOCK_OUT   = st.chan_clk;
    assign APERTURE_RIGHT   = st.apt_r;
    assign APERTURE_LEFT    = st.apt_l;
    assign LOCK             = st.lock;
    assign TWO_THIRDS_CLOCK = st.two_thirds;
    assign CLK_4MHZ_OUT     = st.clk4;
    assign CLK_HI_OUT       = st.clk_hi;
    assign DIG_OUT          = st.dig_out;
    assign DIG_OUT_ENABLE   = st.dig_en;
    assign SENSE_REPORT     = st.sense;
    assign SEQ_GATE         = st.seq_gate;
    assign SPINDLE_ON       = st.spindle;

endmodule : cdo_audio_out

// ==== test/cdo_audio_out_properties.sv ====
// checker for the cd audio output port: strobes, clocks, lock, focus
// assumes binding to cdo_audio_out at nominal pitch
`timescale 1ns/10ps
module cdo_audio_out_properties #(
    parameter int LOCK_SAMPLE_CYC = 16
) (
    input wire logic                     CLK,
    input wire logic                     RSTN,
    input wire cdo_pkg::cdo_apb_req_type APB_REQ,
    input wire cdo_pkg::cdo_apb_rsp_type APB_RSP,
    input wire logic                     FRAME_SYNC_GOOD,
    input wire logic                     FOCUS_GOOD,
    input wire logic                     CHAN_CLOCK_OUT,
    input wire logic                     WORD_CLOCK_OUT,
    input wire logic                     APERTURE_RIGHT,
    input wire logic                     APERTURE_LEFT,
    input wire logic                     LOCK,
    input wire logic                     DIG_OUT,
    input wire logic                     DIG_OUT_ENABLE,
    input wire logic                     SENSE_REPORT,
    input wire logic                     SEQ_GATE,
    input wire logic                     SPINDLE_ON
);
    import cdo_pkg::*;
    localparam int LOW_MIN = 7 * LOCK_SAMPLE_CYC;
    localparam int HI_MAX  = LOCK_SAMPLE_CYC + 4;
    logic [15:0] low_run;
    logic [15:0] hi_age;
    logic        commit;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // --------
    // helpers: apb write commit decode and saturating run counters of the sync input
    // --------
    assign commit = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && APB_RSP.pready;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            low_run <= 16'h0;
            hi_age  <= 16'hffff;
        end else begin
            low_run <= FRAME_SYNC_GOOD ? 16'h0 : low_run + 16'(low_run != 16'hffff);
            hi_age  <= FRAME_SYNC_GOOD ? 16'h0 : hi_age + 16'(hi_age != 16'hffff);
        end
    end
    property p_aper; !(APERTURE_LEFT && APERTURE_RIGHT); endproperty
    a_aper: assert property (p_aper) else $error("aperture strobes overlap");
    property p_dout; DIG_OUT |-> DIG_OUT_ENABLE || $past(DIG_OUT_ENABLE); endproperty
    a_dout: assert property (p_dout) else $error("digital out while disabled");
    property p_spin; $rose(SPINDLE_ON) |-> $past(commit) || $past(commit, 2); endproperty
    a_spin: assert property (p_spin) else $error("spindle on without a write");
    property p_chan; $rose(CHAN_CLOCK_OUT) |=> CHAN_CLOCK_OUT[*8] ##[180:260] $fell(CHAN_CLOCK_OUT); endproperty
    a_chan: assert property (p_chan) else $error("channel clock half period wrong");
    property p_word; $changed(WORD_CLOCK_OUT) |=> $stable(WORD_CLOCK_OUT)[*8] ##[90:130] $changed(WORD_CLOCK_OUT);
    endproperty
    a_word: assert property (p_word) else $error("word clock half period wrong");
    property p_lfall; $fell(LOCK) |-> low_run >= LOW_MIN; endproperty
    a_lfall: assert property (p_lfall) else $error("lock dropped too early");
    property p_lrise; $rose(LOCK) |-> hi_age <= HI_MAX; endproperty
    a_lrise: assert property (p_lrise) else $error("lock rose without good sync");
    property p_sense; FOCUS_GOOD[*5] |-> SENSE_REPORT; endproperty
    a_sense: assert property (p_sense) else $error("sense not following focus");
    property p_gate; (!FOCUS_GOOD)[*5] |-> !SENSE_REPORT && !SEQ_GATE; endproperty
    a_gate: assert property (p_gate) else $error("sense or gate without focus");
endmodule : cdo_audio_out_properties

// ==== test/cdo_dac_model.sv ====
// converter front end: captures 64-slot left words, lsb first
// assumes bit clock, data and channel clock straight from the pins
`timescale 1ns/10ps
module cdo_dac_model (
    input  wire logic        bclk,
    input  wire logic        sdata,
    input  wire logic        chan_clock_out,
    output      logic [15:0] left_word
);
    logic [15:0] shift;
    int          count = 16;
    // a new left word starts at the channel clock rise
    always @(posedge chan_clock_out) count = 0;
    // capture on the bit clock rise, mid-bit, so data has settled; sign fill ignored
    always @(posedge bclk) begin
        if (chan_clock_out && count < 16) begin
            shift[count] = sdata;
            count++;
            if (count == 16) left_word = shift;
        end
    end
endmodule : cdo_dac_model

// ==== test/tb.sv ====
// self-checking bench for the cd audio output port
// assumes package, design, checker and converter model compiled first
`timescale 1ns/10ps
module tb;
    import cdo_pkg::*;
    localparam int LSC = 16;
    logic            clk, rstn, aud_wr, sync_good, focus, rerr;
    logic            wck, cck, apr, apl, lock, dout, doe, sense, gate, spin;
    logic [15:0]     pins, left_word;
    logic [31:0]     rd;
    logic            c4;
    int              c4n = 0;
    cdo_apb_req_type req;
    cdo_apb_rsp_type rsp;
    cdo_sample_type  smp;
    cdo_mon_type     mon;
    int              fails = 0, samples_checked = 0, cycles = 0;
    cdo_audio_out #(.DEPTH(16), .LOCK_SAMPLE_CYC(LSC)) cdo_audio_out_inst (.CLK(clk), .RSTN(rstn),
        .APB_REQ(req), .APB_RSP(rsp), .AUD_WR(aud_wr), .AUD_SAMPLE(smp), .FRAME_SYNC_GOOD(sync_good),
        .FOCUS_GOOD(focus), .MON_IN(mon), .AUDIO_PINS(pins), .WORD_CLOCK_OUT(wck), .CHAN_CLOCK_OUT(cck),
        .APERTURE_RIGHT(apr), .APERTURE_LEFT(apl), .LOCK(lock), .TWO_THIRDS_CLOCK(), .CLK_4MHZ_OUT(c4),
        .CLK_HI_OUT(), .DIG_OUT(dout), .DIG_OUT_ENABLE(doe), .SENSE_REPORT(sense), .SEQ_GATE(gate),
        .SPINDLE_ON(spin));
    cdo_dac_model cdo_dac_model_inst (.bclk(pins[12]), .sdata(pins[13]), .chan_clock_out(pins[11]), .left_word(left_word));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count rises of the pitched 4 MHz clock over a measured window
    always @(posedge c4) c4n++;
    // hang guard: the whole sequence needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; entered just after a rising edge, waits for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        // look at pready mid-cycle where it is settled, then take the answer at the next rise
        do begin
            @(negedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n == 20) fails++;
        @(posedge clk);
        rd = rsp.prdata;
        rerr = rsp.pslverr;
        req <= '0;
        repeat (3) @(posedge clk);
    endtask : apb
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // --------
    // main sequence
    // --------
    initial begin
        rstn = 1'b0; aud_wr = 1'b0; smp = '0; sync_good = 1'b0; focus = 1'b0; mon = 8'ha5; req = '0;
        repeat (5) @(posedge clk);
        chk({lock, spin, doe, pins}, 32'h0);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, CDO_PITCH_OFF, 32'h0); chk(rd, 32'(CDO_PITCH_RESET));
        apb(1'b0, 12'h00c, 32'h0); chk({31'h0, rerr}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, CDO_CTRL_OFF, 32'h1c); chk({spin, doe}, 2'b11);
        focus <= 1'b1; repeat (6) @(posedge clk); chk({sense, gate}, 2'b11);
        focus <= 1'b0; repeat (6) @(posedge clk); chk({sense, gate}, 2'b00);
        sync_good <= 1'b1; repeat (LSC + 6) @(posedge clk); chk(lock, 1'b1);
        // twenty back-to-back frames overrun the sixteen-deep buffer
        smp <= '{1'b0, 16'h1234, 16'hbeef}; aud_wr <= 1'b1; repeat (20) @(posedge clk); aud_wr <= 1'b0;
        apb(1'b0, CDO_STATUS_OFF, 32'h0); chk(rd[CDO_ST_OVF], 1'b1);
        apb(1'b1, CDO_STATUS_OFF, 32'h2); apb(1'b0, CDO_STATUS_OFF, 32'h0); chk(rd[CDO_ST_OVF], 1'b0);
        chk({pins[7], pins[3:0]}, 5'h15);
        repeat (1400) @(posedge clk); chk(left_word, 16'h1234);
        chk(dout, pins[13]);
        apb(1'b1, CDO_CTRL_OFF, 32'h1d); c4n = 0; repeat (1000) @(posedge clk);
        chk(32'(c4n >= 210 && c4n <= 213), 32'h1);
        apb(1'b0, CDO_STATUS_OFF, 32'h0); chk(rd[CDO_ST_PAR], 1'b1);
        @(posedge apl); repeat (4) @(posedge clk); chk(pins, 16'h1234);
        @(posedge apr); repeat (4) @(posedge clk); chk(pins, 16'hbeef);
        sync_good <= 1'b0; repeat (5 * LSC) @(posedge clk); chk(lock, 1'b1);
        repeat (4 * LSC + 8) @(posedge clk); chk(lock, 1'b0);
        results();
    end
endmodule : tb
bind cdo_audio_out cdo_audio_out_properties #(.LOCK_SAMPLE_CYC(LOCK_SAMPLE_CYC)) cdo_audio_out_properties_inst (
    .CLK(CLK), .RSTN(RSTN), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .FRAME_SYNC_GOOD(FRAME_SYNC_GOOD),
    .FOCUS_GOOD(FOCUS_GOOD), .CHAN_CLOCK_OUT(CHAN_CLOCK_OUT), .WORD_CLOCK_OUT(WORD_CLOCK_OUT),
    .APERTURE_RIGHT(APERTURE_RIGHT), .APERTURE_LEFT(APERTURE_LEFT), .LOCK(LOCK), .DIG_OUT(DIG_OUT),
    .DIG_OUT_ENABLE(DIG_OUT_ENABLE), .SENSE_REPORT(SENSE_REPORT), .SEQ_GATE(SEQ_GATE), .SPINDLE_ON(SPINDLE_ON));
